// File: src/tc_link_state_and_tx_control_regs.sv
// register bank: link state readback, sync flags, soft resets, tx and rx count controls
// Notes on behaviour
// [R1] link select field picks readback link
// [R2] readback refreshed after link select write
// [R3] state code: hunt, presync, sync, reserved
// [R4] bit four toggles on every write
// [R5] sync flags are live per link
// [R6] bit seven write one resets receiver
// [R7] bit six write one resets transmitter
// [R8] bit five write one resets counters
// [R9] bits seven to five together: global
// [R10] eight tx registers, link pair each
// [R11] tx count mode: user or all
// [R12] coset bit zero adds coset to HEC
// [R13] scramble bit one scrambles link cells
// [R14] software writes reserved tx bits properly
// [R15] software writes reset bits four:three zero
// [R16] rx count select per link
// [R17] unused upper bits read zero
// [R18] presync to sync after delta cells
// [R19] soft reset bits self clear
`timescale 1ns/1ps
`default_nettype none
`include "tc_regs_consts.svh"
module tc_link_state_and_tx_control_regs
    import tc_regs_pkg::*;
#(
    parameter int NUM_LINKS = 16,
    parameter int RST_PULSE = `SOFT_RST_CYCLES,
    parameter logic [3:0] DELTA = `DELTA_DEFAULT
) (
    input wire logic CLK, // system clock
    input wire logic SYS_RST, // async reset, high
    input wire logic CE, // clock enable
    input wire logic [`ADDR_W-1:0] ADDR, // register address
    input wire logic WR, // one-cycle write strobe
    input wire logic RD, // one-cycle read strobe
    input wire logic [15:0] WDATA, // write data
    output logic [15:0] RDATA, // read data, one cycle after RD
    input wire logic [31:0] DELIN_STATE, // 2 bits per link from delineation machines
    input wire logic [15:0] HEC_OK, // per link: cell with good HEC seen
    input wire logic [15:0] HEC_BAD, // per link: cell with bad HEC seen
    output logic [15:0] DELTA_REACHED, // per link: delta good cells in presync
    output logic RX_RESET, // receive path reset
    output logic TX_RESET, // transmit path reset
    output logic CNT_RESET, // counter reset
    output logic GLOBAL_RESET, // whole device soft reset
    output logic [15:0] TX_USER_ONLY, // per link tx count mode
    output logic [15:0] TX_COSET_OFF, // per link coset omitted
    output logic [15:0] TX_SCRAMBLE, // per link scrambling
    output logic [15:0] RX_USER_ONLY // per link rx count mode
);
    initial begin
        if (NUM_LINKS != 16 || RST_PULSE < 1 || RST_PULSE > 255 || DELTA == 4'h0) begin
            $error("unsupported parameter value");
        end
    end

    logic [3:0] link_sel;
    logic toggle;
    logic [1:0] state_rb;
    logic [15:0] sync_flags;
    logic [15:0] tx_ctrl [8];
    logic [15:0] rx_cnt_mode;
    logic [2:0] rst_bits;
    logic [15:0] soft_rst_rw;
    logic [7:0] rst_cnt;
    logic global_pend;
    rst_seq_t rst_seq;
    logic [3:0] good_cnt [16];
    logic sel_written;

    function automatic logic hit(input logic [`ADDR_W-1:0] a, input logic [`ADDR_W-1:0] ofs);
        hit = (a == ofs);
    endfunction

    function automatic logic [1:0] link_state(input logic [31:0] all, input logic [3:0] n);
        link_state = all[{n, 1'b0} +: 2];
    endfunction

    wire logic wr_tx = WR && ADDR >= `OFS_TX_CTRL_BASE && ADDR <= `OFS_TX_CTRL_LAST;
    wire logic [2:0] tx_idx = ADDR[2:0];

    // link select register and write toggle
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            link_sel <= 4'h0;
            toggle <= 1'b0;
            sel_written <= 1'b0;
        end else if (CE) begin
            sel_written <= WR && hit(ADDR, `OFS_LINK_SEL);
            if (WR) begin
                toggle <= ~toggle; // [R4]
            end
            if (WR && hit(ADDR, `OFS_LINK_SEL)) begin
                link_sel <= WDATA[3:0]; // [R1]
            end
        end
    end

    // readback refreshed once the select write has completed
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            state_rb <= 2'h0;
        end else if (CE && sel_written) begin
            state_rb <= link_state(DELIN_STATE, link_sel); // [R1] [R2] [R3]
        end
    end

    // live sync flags, one register stage
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            sync_flags <= 16'h0000;
        end else if (CE) begin
            for (int i = 0; i < 16; i++) begin
                sync_flags[i] <= (link_state(DELIN_STATE, 4'(i)) == DELIN_SYNC); // [R5]
            end
        end
    end

    // tx link pair control registers
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            for (int i = 0; i < 8; i++) begin
                tx_ctrl[i] <= `RST_TX_CTRL;
            end
        end else if (CE && wr_tx) begin
            tx_ctrl[tx_idx] <= WDATA; // [R10] [R14]
        end
    end

    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            TX_USER_ONLY <= 16'h0000;
            TX_COSET_OFF <= 16'h0000;
            TX_SCRAMBLE <= 16'h0000;
        end else if (CE) begin
            for (int i = 0; i < 8; i++) begin
                TX_USER_ONLY[i] <= tx_ctrl[i][`TX_BIT_CNT_LO]; // [R11]
                TX_USER_ONLY[i+8] <= tx_ctrl[i][`TX_BIT_CNT_HI]; // [R11]
                TX_COSET_OFF[i] <= tx_ctrl[i][`TX_BIT_COSET_LO]; // [R12]
                TX_COSET_OFF[i+8] <= tx_ctrl[i][`TX_BIT_COSET_HI]; // [R12]
                TX_SCRAMBLE[i] <= tx_ctrl[i][`TX_BIT_SCR_LO]; // [R13]
                TX_SCRAMBLE[i+8] <= tx_ctrl[i][`TX_BIT_SCR_HI]; // [R13]
            end
        end
    end

    // rx count mode select
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            rx_cnt_mode <= `RST_RX_CNT_MODE;
            RX_USER_ONLY <= 16'h0000;
        end else if (CE) begin
            if (WR && hit(ADDR, `OFS_RX_CNT_MODE)) begin
                rx_cnt_mode <= WDATA;
            end
            RX_USER_ONLY <= rx_cnt_mode; // [R16]
        end
    end

    // soft reset bits: held for RST_PULSE cycles then cleared by hardware
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            rst_bits <= 3'h0;
            soft_rst_rw <= `RST_SOFT_RST;
            rst_cnt <= 8'h00;
            global_pend <= 1'b0;
            rst_seq <= RST_IDLE;
        end else if (CE) begin
            if (WR && hit(ADDR, `OFS_SOFT_RST)) begin
                soft_rst_rw <= WDATA & `SOFT_RST_RW_MASK; // [R15]
            end
            case (rst_seq)
                RST_IDLE: begin
                    if (WR && hit(ADDR, `OFS_SOFT_RST) && WDATA[7:5] != 3'h0) begin
                        rst_bits <= WDATA[7:5]; // [R6] [R7] [R8]
                        global_pend <= (WDATA[7:5] == 3'h7); // [R9]
                        rst_cnt <= 8'(RST_PULSE - 1);
                        rst_seq <= RST_BUSY;
                    end
                end
                RST_BUSY: begin
                    if (rst_cnt == 8'h00) begin
                        if (WR && hit(ADDR, `OFS_SOFT_RST) && WDATA[7:5] != 3'h0) begin
                            // a write setting any of bits seven to five on the last cycle wins over the self clear
                            rst_bits <= WDATA[7:5];
                            global_pend <= (WDATA[7:5] == 3'h7); // [R9]
                            rst_cnt <= 8'(RST_PULSE - 1);
                        end else begin
                            rst_bits <= 3'h0; // [R19]
                            global_pend <= 1'b0;
                            rst_seq <= RST_IDLE;
                        end
                    end else begin
                        if (WR && hit(ADDR, `OFS_SOFT_RST)) begin
                            rst_bits <= rst_bits | WDATA[7:5];
                        end
                        rst_cnt <= rst_cnt - 8'h01;
                    end
                end
                default: rst_seq <= RST_IDLE;
            endcase
        end
    end

    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            RX_RESET <= 1'b0;
            TX_RESET <= 1'b0;
            CNT_RESET <= 1'b0;
            GLOBAL_RESET <= 1'b0;
        end else if (CE) begin
            RX_RESET <= rst_bits[2]; // [R6]
            TX_RESET <= rst_bits[1]; // [R7]
            CNT_RESET <= rst_bits[0]; // [R8]
            GLOBAL_RESET <= global_pend; // [R9]
        end
    end

    // consecutive good HEC count in presync, per link
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            for (int i = 0; i < 16; i++) begin
                good_cnt[i] <= 4'h0;
            end
            DELTA_REACHED <= 16'h0000;
        end else if (CE) begin
            for (int i = 0; i < 16; i++) begin
                DELTA_REACHED[i] <= 1'b0;
                if (link_state(DELIN_STATE, 4'(i)) != DELIN_PRESYNC || HEC_BAD[i] || RX_RESET) begin
                    good_cnt[i] <= 4'h0;
                end else if (HEC_OK[i]) begin
                    if (good_cnt[i] + 4'h1 >= DELTA) begin
                        DELTA_REACHED[i] <= 1'b1; // [R18]
                        good_cnt[i] <= 4'h0;
                    end else begin
                        good_cnt[i] <= good_cnt[i] + 4'h1;
                    end
                end
            end
        end
    end

    // read mux, unused bits zero
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            RDATA <= 16'h0000;
        end else if (CE && RD) begin
            RDATA <= 16'h0000; // [R17]
            if (hit(ADDR, `OFS_LINK_SEL)) begin
                RDATA <= {11'h000, toggle, link_sel}; // [R17]
            end else if (hit(ADDR, `OFS_STATE_RB)) begin
                RDATA <= {14'h0000, state_rb};
            end else if (hit(ADDR, `OFS_SYNC_FLAGS)) begin
                RDATA <= sync_flags;
            end else if (hit(ADDR, `OFS_SOFT_RST)) begin
                RDATA <= soft_rst_rw | {8'h00, rst_bits, 5'h00};
            end else if (ADDR >= `OFS_TX_CTRL_BASE && ADDR <= `OFS_TX_CTRL_LAST) begin
                RDATA <= tx_ctrl[tx_idx];
            end else if (hit(ADDR, `OFS_RX_CNT_MODE)) begin
                RDATA <= rx_cnt_mode;
            end
        end
    end

    chk_toggle_on_write: assert property (@(posedge CLK) disable iff (SYS_RST) // [R4]
        CE && WR |=> toggle != $past(toggle))
        else $error("toggle did not flip on write");
    chk_readback_refresh: assert property (@(posedge CLK) disable iff (SYS_RST) // [R2]
        CE && WR && hit(ADDR, `OFS_LINK_SEL) ##1 CE |=>
        state_rb == link_state($past(DELIN_STATE), $past(link_sel)))
        else $error("readback not refreshed");
    chk_sync_live: assert property (@(posedge CLK) disable iff (SYS_RST) // [R5]
        CE |=> sync_flags[0] == ($past(DELIN_STATE[1:0]) == DELIN_SYNC))
        else $error("sync flag wrong");
    chk_rx_reset_go: assert property (@(posedge CLK) disable iff (SYS_RST) // [R6]
        CE && WR && hit(ADDR, `OFS_SOFT_RST) && WDATA[7] && rst_seq == RST_IDLE ##1 CE
        |=> RX_RESET)
        else $error("receiver reset missing");
    chk_zero_no_reset: assert property (@(posedge CLK) disable iff (SYS_RST) // [R7]
        CE && rst_seq == RST_IDLE && !(WR && hit(ADDR, `OFS_SOFT_RST)) |=> !rst_bits[1])
        else $error("spurious transmitter reset");
    chk_global_reset: assert property (@(posedge CLK) disable iff (SYS_RST) // [R9]
        GLOBAL_RESET |-> RX_RESET && TX_RESET && CNT_RESET)
        else $error("global reset without all parts");
    chk_reset_clears: assert property (@(posedge CLK) disable iff (SYS_RST) // [R19]
        rst_seq == RST_BUSY && rst_cnt == 8'h00 && CE && !(WR && hit(ADDR, `OFS_SOFT_RST))
        |=> rst_bits == 3'h0)
        else $error("soft reset did not self clear");
    chk_scramble_map: assert property (@(posedge CLK) disable iff (SYS_RST) // [R13]
        CE |=> TX_SCRAMBLE[8] == $past(tx_ctrl[0][`TX_BIT_SCR_HI]))
        else $error("scramble mapping wrong");
    chk_upper_zero: assert property (@(posedge CLK) disable iff (SYS_RST) // [R17]
        CE && RD && hit(ADDR, `OFS_STATE_RB) |=> RDATA[15:2] == 14'h0000)
        else $error("unused bits not zero");
    chk_rx_count_mode: assert property (@(posedge CLK) disable iff (SYS_RST) // [R16]
        CE |=> RX_USER_ONLY == $past(rx_cnt_mode))
        else $error("rx count mode not passed");
    // state code in the low two bits of the readback
    chk_state_code: assert property (@(posedge CLK) disable iff (SYS_RST) // [R3]
        CE && RD && hit(ADDR, `OFS_STATE_RB) |=> RDATA[1:0] == $past(state_rb))
        else $error("state code not returned");
    // select field captures the written link number
    chk_sel_field: assert property (@(posedge CLK) disable iff (SYS_RST) // [R1]
        CE && WR && hit(ADDR, `OFS_LINK_SEL) |=> link_sel == $past(WDATA[3:0]))
        else $error("link select not stored");
    // each tx register takes the whole written word
    chk_tx_write: assert property (@(posedge CLK) disable iff (SYS_RST) // [R10]
        CE && wr_tx |=> tx_ctrl[$past(tx_idx)] == $past(WDATA))
        else $error("tx register not stored");
    // high byte count bit serves link eight
    chk_tx_count_map: assert property (@(posedge CLK) disable iff (SYS_RST) // [R11]
        CE |=> TX_USER_ONLY[8] == $past(tx_ctrl[0][`TX_BIT_CNT_HI]))
        else $error("tx count mapping wrong");
    // low byte coset bit serves link zero
    chk_coset_map: assert property (@(posedge CLK) disable iff (SYS_RST) // [R12]
        CE |=> TX_COSET_OFF[0] == $past(tx_ctrl[0][`TX_BIT_COSET_LO]))
        else $error("coset mapping wrong");
    // bit six written one starts a transmit reset
    chk_tx_reset_go: assert property (@(posedge CLK) disable iff (SYS_RST) // [R7]
        CE && WR && hit(ADDR, `OFS_SOFT_RST) && WDATA[6] && rst_seq == RST_IDLE ##1 CE
        |=> TX_RESET)
        else $error("transmitter reset missing");
    // bit five written one starts a counter reset
    chk_cnt_reset_go: assert property (@(posedge CLK) disable iff (SYS_RST) // [R8]
        CE && WR && hit(ADDR, `OFS_SOFT_RST) && WDATA[5] && rst_seq == RST_IDLE ##1 CE
        |=> CNT_RESET)
        else $error("counter reset missing");
    // all three bits in one write start a global reset
    chk_global_go: assert property (@(posedge CLK) disable iff (SYS_RST) // [R9]
        CE && WR && hit(ADDR, `OFS_SOFT_RST) && WDATA[7:5] == 3'h7 && rst_seq == RST_IDLE
        ##1 CE |=> GLOBAL_RESET)
        else $error("global reset missing");
    // no delta pulse on link zero outside presync
    chk_delta_presync: assert property (@(posedge CLK) disable iff (SYS_RST) // [R18]
        CE && link_state(DELIN_STATE, 4'h0) != DELIN_PRESYNC |=> !DELTA_REACHED[0])
        else $error("delta pulse outside presync");
    // link select read keeps its upper bits zero
    chk_sel_upper_zero: assert property (@(posedge CLK) disable iff (SYS_RST) // [R17]
        CE && RD && hit(ADDR, `OFS_LINK_SEL) |=> RDATA[15:5] == 11'h000)
        else $error("select upper bits not zero");
    // rx count select takes the whole written word
    chk_rx_cnt_write: assert property (@(posedge CLK) disable iff (SYS_RST) // [R16]
        CE && WR && hit(ADDR, `OFS_RX_CNT_MODE) |=> rx_cnt_mode == $past(WDATA))
        else $error("rx count select not stored");
    // clock enable low freezes the select state
    chk_freeze: assert property (@(posedge CLK) disable iff (SYS_RST)
        !CE |=> toggle == $past(toggle) && link_sel == $past(link_sel))
        else $error("state moved with enable low");
endmodule // tc_link_state_and_tx_control_regs
`default_nettype wire

// File: src/tc_regs_consts.svh
// register offsets, field positions and reset values of the link control registers
`ifndef TC_REGS_CONSTS_SVH
`define TC_REGS_CONSTS_SVH
`define ADDR_W 11
`define OFS_LINK_SEL 11'h0dc
`define OFS_STATE_RB 11'h0e4
`define OFS_SYNC_FLAGS 11'h0e6
`define OFS_SOFT_RST 11'h299
`define OFS_TX_CTRL_BASE 11'h318
`define OFS_TX_CTRL_LAST 11'h31f
`define OFS_RX_CNT_MODE 11'h402
`define RST_LINK_SEL 16'h0000
`define RST_TX_CTRL 16'h0808
`define RST_RX_CNT_MODE 16'h0000
`define RST_SOFT_RST 16'h0000
`define BIT_TOGGLE 4
`define BIT_RST_RX 7
`define BIT_RST_TX 6
`define BIT_RST_CNT 5
`define SOFT_RST_RW_MASK 16'h011f
`define TX_BIT_CNT_HI 15
`define TX_BIT_COSET_HI 13
`define TX_BIT_SCR_HI 12
`define TX_BIT_CNT_LO 7
`define TX_BIT_COSET_LO 5
`define TX_BIT_SCR_LO 4
`define SOFT_RST_CYCLES 4
`define DELTA_DEFAULT 4'h6
`endif

// File: src/tc_regs_pkg.sv
// types shared by the link state and transmit control register bank
package tc_regs_pkg;
    typedef enum logic [1:0] {
        DELIN_HUNT = 2'h0,
        DELIN_PRESYNC = 2'h1,
        DELIN_SYNC = 2'h2,
        DELIN_RSVD = 2'h3
    } delin_state_t;
    typedef enum {RST_IDLE, RST_BUSY} rst_seq_t;
endpackage

// File: test/tb_tc_link_state_and_tx_control_regs.sv
// self-checking bench for the link state and tx control register bank
`timescale 1ns/1ps
`default_nettype none
`include "tc_regs_consts.svh"
module tb;
    import tc_regs_pkg::*;
    localparam int P = 3;
    logic CLK = 1'b0;
    logic SYS_RST = 1'b1;
    logic CE = 1'b1;
    logic [`ADDR_W-1:0] ADDR = '0;
    logic WR = 1'b0;
    logic RD = 1'b0;
    logic [15:0] WDATA = '0;
    logic [31:0] DELIN_STATE = '0;
    logic [15:0] HEC_OK = '0;
    logic [15:0] HEC_BAD = '0;
    logic [15:0] RDATA, DELTA_REACHED, TX_USER_ONLY, TX_COSET_OFF, TX_SCRAMBLE, RX_USER_ONLY;
    logic RX_RESET, TX_RESET, CNT_RESET, GLOBAL_RESET;
    int miscompares = 0;
    int compares = 0;
    int cycles = 0;
    int n[5];
    logic [15:0] expq[$];
    logic [15:0] txv[8];
    logic [15:0] eu, ec, es, d, sf;
    logic [31:0] seed = 32'h1a6b;
    logic [31:0] st;
    logic pend = 1'b0;
    logic tog = 1'b0;
    logic [15:0] vals[5] = '{16'h0080, 16'h0040, 16'h0020, 16'h0000, 16'h00e0};

    tc_link_state_and_tx_control_regs #(.RST_PULSE(P)) u_tc_link_state_and_tx_control_regs (
        .CLK(CLK), .SYS_RST(SYS_RST), .CE(CE), .ADDR(ADDR), .WR(WR), .RD(RD),
        .WDATA(WDATA), .RDATA(RDATA), .DELIN_STATE(DELIN_STATE), .HEC_OK(HEC_OK),
        .HEC_BAD(HEC_BAD), .DELTA_REACHED(DELTA_REACHED), .RX_RESET(RX_RESET),
        .TX_RESET(TX_RESET), .CNT_RESET(CNT_RESET), .GLOBAL_RESET(GLOBAL_RESET),
        .TX_USER_ONLY(TX_USER_ONLY), .TX_COSET_OFF(TX_COSET_OFF),
        .TX_SCRAMBLE(TX_SCRAMBLE), .RX_USER_ONLY(RX_USER_ONLY));

    always #5 CLK = ~CLK;

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task report_and_stop();
        if (miscompares == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // each access holds its strobe for one edge; consecutive calls run back to back
    task automatic wr(input logic [`ADDR_W-1:0] a, input logic [15:0] v);
        ADDR = a;
        WDATA = v;
        RD = 1'b0;
        WR = 1'b1;
        tog = tog ^ CE;
        @(posedge CLK);
        #1;
    endtask

    task automatic rd(input logic [`ADDR_W-1:0] a, input logic [15:0] e);
        ADDR = a;
        WR = 1'b0;
        RD = 1'b1;
        expq.push_back(e);
        @(posedge CLK);
        #1;
    endtask

    task automatic idle();
        WR = 1'b0;
        RD = 1'b0;
        @(posedge CLK);
        #1;
    endtask

    // read results appear in the cycle after the taking edge
    always @(posedge CLK) pend <= RD & CE & ~SYS_RST;
    always @(negedge CLK) begin
        if (pend) begin
            chk(RDATA, expq.pop_front(), "read data");
        end
        n[0] += RX_RESET;
        n[1] += TX_RESET;
        n[2] += CNT_RESET;
        n[3] += GLOBAL_RESET;
        n[4] += DELTA_REACHED[0];
    end

    always @(posedge CLK) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            report_and_stop();
        end
    end

    initial begin
        repeat (8) @(posedge CLK);
        #1;
        SYS_RST = 1'b0;
        for (int k = 0; k < 8; k++) rd(`OFS_TX_CTRL_BASE + k, `RST_TX_CTRL);
        rd(`OFS_LINK_SEL, `RST_LINK_SEL);
        rd(`OFS_RX_CNT_MODE, `RST_RX_CNT_MODE);
        for (int k = 0; k < 8; k++) begin
            txv[k] = (rnd() & 16'hb0b0) | 16'h0808;
            {eu[k+8], eu[k], ec[k+8], ec[k], es[k+8], es[k]} =
                {txv[k][15], txv[k][7], txv[k][13], txv[k][5], txv[k][12], txv[k][4]};
            wr(`OFS_TX_CTRL_BASE + k, txv[k]);
        end
        for (int k = 0; k < 8; k++) rd(`OFS_TX_CTRL_BASE + k, txv[k]);
        idle();
        chk(TX_USER_ONLY, eu, "tx count mode");
        chk(TX_COSET_OFF, ec, "tx coset off");
        chk(TX_SCRAMBLE, es, "tx scramble");
        CE = 1'b0;
        wr(`OFS_TX_CTRL_BASE, ~txv[0]);
        CE = 1'b1;
        rd(`OFS_TX_CTRL_BASE, txv[0]);
        d = rnd();
        wr(`OFS_RX_CNT_MODE, d);
        rd(`OFS_RX_CNT_MODE, d);
        idle();
        chk(RX_USER_ONLY, d, "rx count mode");
        for (int k = 0; k < 16; k++) begin
            for (int j = 0; j < 16; j++) begin
                st[2*j+:2] = 2'(rnd() % 3);
                sf[j] = (st[2*j+:2] == DELIN_SYNC);
            end
            DELIN_STATE = st;
            wr(`OFS_LINK_SEL, 16'hffe0 | 16'(k));
            idle();
            idle();
            rd(`OFS_STATE_RB, {14'h0, st[2*k+:2]});
            rd(`OFS_LINK_SEL, {11'h0, tog, 4'(k)});
            rd(`OFS_SYNC_FLAGS, sf);
        end
        rd(11'h7ff, 16'h0000);
        wr(11'h7ff, 16'hffff);
        rd(`OFS_LINK_SEL, {11'h0, tog, 4'hf});
        DELIN_STATE = {30'h0, DELIN_PRESYNC};
        idle();
        n[4] = 0;
        for (int i = 0; i < 12; i++) begin
            HEC_OK = {15'h0, i != 5};
            HEC_BAD = {15'h0, i == 5};
            @(posedge CLK);
            #1;
            HEC_OK = '0;
            HEC_BAD = '0;
            @(posedge CLK);
            #1;
        end
        repeat (4) idle();
        chk(16'(n[4]), 16'h1, "delta pulses");
        // global reset runs last since it may clear the whole bank
        foreach (vals[i]) begin
            n[0:3] = '{0, 0, 0, 0};
            wr(`OFS_SOFT_RST, vals[i]);
            repeat (10) idle();
            chk(16'(n[0]), vals[i][7] ? 16'(P) : 16'h0, "rx reset");
            chk(16'(n[1]), vals[i][6] ? 16'(P) : 16'h0, "tx reset");
            chk(16'(n[2]), vals[i][5] ? 16'(P) : 16'h0, "counter reset");
            chk(16'(n[3] != 0), 16'(vals[i] == 16'h00e0), "global reset");
            rd(`OFS_SOFT_RST, 16'h0000);
            idle();
        end
        repeat (3) idle();
        report_and_stop();
    end
endmodule // tb
`default_nettype wire
